// *** host_model.sv ***
// Host side of the register port.
`timescale 1ns/1ns
module host_model (
  input wire clk_sys,
  input wire reg_ack_ff,
  input wire [7:0] reg_rdata_ff,
  output reg reg_wr = 0,
  output reg reg_rd = 0,
  output reg [5:0] reg_addr = 0,
  output reg [7:0] reg_wdata = 0
);
  // Released lines show inverted values so a stale address is never mistaken for a live one.
  task xfer(input w, input [5:0] a, input [7:0] d, output [7:0] q);
    integer i;
    @(posedge clk_sys) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge clk_sys) #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    for (i = 0; i < 3 && reg_ack_ff !== 1'b1; i = i + 1) @(posedge clk_sys) #1;
    if (reg_ack_ff !== 1'b1) supply_can_status_irq_regs_test.hang;
    q = reg_rdata_ff;
  endtask
endmodule

// *** sbc_regs_checker.sv ***
// Port-level assertions for the status and transceiver register bank.
`timescale 1ns/1ns
`include "sbc_regs_defines.vh"
module sbc_regs_checker (
  input wire clk_sys,
  input wire rst,
  input wire reset_pin_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  input wire wakeup,
  input wire [1:0] chip_mode,
  input wire force_term,
  input wire [2:0] transceiver_state_ff
);
  wire [2:0] xs = transceiver_state_ff;
  wire rd_c2 = reg_rd && reg_addr == `OFF_IRQ_CAUSE_TWO;
  wire rd_e2 = reg_rd && reg_addr == `OFF_IRQ_EN_TWO;
  wire ok_x = chip_mode != `MODE_SLEEP && !force_term;
  wire wr_rx = reg_wr && reg_addr == `OFF_XCVR_CTRL && reg_wdata[2:0] == `XS_RX_ONLY;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_src; rd_c2 && $stable(wakeup) |=> reg_rdata_ff[0] == $past(wakeup); endproperty
  a_src: assert property (p_src) else $error("source copy differs");
  property p_codes; xs inside {3'h0, 3'h2, 3'h3}; endproperty
  a_codes: assert property (p_codes) else $error("illegal state code");
  property p_wrx; wr_rx && ok_x ##1 ok_x |=> xs == `XS_RX_ONLY; endproperty
  a_wrx: assert property (p_wrx) else $error("selection not entered");
  property p_stby; chip_mode == `MODE_STANDBY [*3] |=> xs != `XS_RX_TX; endproperty
  a_stby: assert property (p_stby) else $error("transmit in standby");
  property p_sleep; chip_mode == `MODE_SLEEP [*3] |=> xs == `XS_TERM_BAT; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not terminated");
  property p_force; force_term [*3] |=> xs == `XS_TERM_BAT; endproperty
  a_force: assert property (p_force) else $error("force not terminated");
  // Without a fresh write, termination must persist because the select bits were cleared.
  property p_keep; xs == 3'h0 && !reg_wr && !$past(reg_wr) |=> xs == 3'h0; endproperty
  a_keep: assert property (p_keep) else $error("left termination");
  property p_mask; (!reset_pin_n && !reg_wr) ##1 !reg_wr ##1 rd_e2 |=> reg_rdata_ff == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("mask survived pin");
  c_sleep: cover property (chip_mode == `MODE_SLEEP [*3]);
  c_force: cover property (force_term [*3]);
  c_pin: cover property (!reset_pin_n);
endmodule
bind supply_can_status_irq_regs sbc_regs_checker chk (.clk_sys, .rst, .reset_pin_n, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .wakeup, .chip_mode, .force_term,
  .transceiver_state_ff);

// *** sbc_regs_defines.vh ***
// Register offsets, field positions, reset values and encodings of the status register bank.
`ifndef SBC_REGS_DEFINES_VH
`define SBC_REGS_DEFINES_VH
`define ADDR_W 6
`define DATA_W 8
`define OFF_LOW_WIRE 6'h17
`define OFF_RESET_CAUSE 6'h18
`define OFF_SUPPLY_STATUS 6'h1b
`define OFF_IRQ_EN_ONE 6'h1d
`define OFF_IRQ_EN_TWO 6'h1e
`define OFF_IRQ_CAUSE_ONE 6'h21
`define OFF_IRQ_CAUSE_TWO 6'h22
`define OFF_XCVR_CTRL 6'h24
`define RESET_CAUSE_POR 3'h5
`define RC_EVT_UNDERVOLT 3'h5
`define RC_EVT_WATCHDOG 3'h6
`define RC_EVT_EXTERNAL 3'h4
`define RC_UNDERVOLT 0
`define RC_WATCHDOG 1
`define RC_EXTERNAL 2
`define SS_BAT_LOW 0
`define SS_BAT_HIGH 1
`define SS_SEC_REG_ON 2
`define SS_SW_OVERTEMP 3
`define XS_TERM_BAT 3'h0
`define XS_RX_ONLY 3'h2
`define XS_RX_TX 3'h3
`define XC_OVERTEMP 3
`define MODE_NORMAL 2'h0
`define MODE_STANDBY 2'h1
`define MODE_SLEEP 2'h2
`endif

// *** sticky_flags.v ***
// Bank of event flags that latch on an event and clear on a read strobe.
`timescale 1ns/1ns
module sticky_flags #(
  parameter WIDTH = 4
) (
  input wire clk_sys,
  input wire rst,
  input wire [WIDTH-1:0] event_in,
  input wire clear,
  output reg [WIDTH-1:0] flags_ff
);
  // An event in the same cycle as the clearing read survives the clear.
  always @(posedge clk_sys)
  begin
    if (rst)
      flags_ff <= {WIDTH{1'b0}};
    else if (clear)
      flags_ff <= event_in;
    else
      flags_ff <= flags_ff | event_in;
  end
endmodule

// *** supply_can_status_irq_regs.v ***
// Status, interrupt mask, interrupt source and transceiver control register bank.
//
// Notes on behaviour
// - Low wire faults: bit0 open, bit2 ground/high short, bit1 battery, bit3 logic supply.
// - Low wire fault bits latch until that register is read; power-on clears them.
// - Reset cause: bit0 undervoltage, bit1 watchdog, both with bit2; external sets bit2.
// - Reset cause bits latch, clear on read; power-on loads 101.
// - Supply status bit0 battery undervoltage, bit1 battery overvoltage.
// - Overvoltage bit is live; bits 3, 2, 0 latch until read.
// - Mask one: battery high, regulator hot, prewarning, battery low; one enables.
// - Mask two: bus failure bit2, serial error bit1, wake-up bit0.
// - Both masks clear on power-on and while the reset pin is low.
// - Source registers are read-only copies of flags at mask bit positions.
// - Reading source registers clears nothing.
// - Transceiver select 000 termination, 010 receive, 011 receive/transmit; reads actual state.
// - Chip mode may override the selected transceiver state.
// - Transceiver control bit3 latches overtemperature, clears on read of that register.
// - Forcing termination clears transceiver control bits 0 and 1.
// - Power-on clears transceiver control; reset pin leaves it unchanged.
`timescale 1ns/1ns
`include "sbc_regs_defines.vh"
module supply_can_status_irq_regs (
  input wire clk_sys,
  input wire rst,
  input wire reset_pin_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  output reg [`DATA_W-1:0] reg_rdata_ff,
  output reg reg_ack_ff,
  input wire low_wire_open,
  input wire low_wire_short_gnd,
  input wire low_wire_short_bat,
  input wire low_wire_short_vdd,
  input wire undervoltage_reset,
  input wire watchdog_reset,
  input wire external_reset,
  input wire battery_fail,
  input wire battery_high,
  input wire secondary_regulator_on,
  input wire switched_supply_overtemp,
  input wire regulator_hot,
  input wire temp_prewarn,
  input wire bus_failure,
  input wire serial_error,
  input wire wakeup,
  input wire transceiver_overtemp,
  input wire [1:0] chip_mode,
  input wire force_term,
  output reg [2:0] transceiver_state_ff,
  output reg irq_ff
);
  wire rd_low_wire = reg_rd && reg_addr == `OFF_LOW_WIRE;
  wire rd_reset_cause = reg_rd && reg_addr == `OFF_RESET_CAUSE;
  wire rd_supply = reg_rd && reg_addr == `OFF_SUPPLY_STATUS;
  wire rd_xcvr = reg_rd && reg_addr == `OFF_XCVR_CTRL;
  wire wr_xcvr = reg_wr && reg_addr == `OFF_XCVR_CTRL;
  wire [3:0] low_wire_flags;
  wire [3:0] supply_latched;
  wire [0:0] xcvr_ot;
  wire [2:0] xcvr_sel;
  wire [2:0] xcvr_state;
  reg [2:0] reset_cause_ff;
  reg [3:0] irq_enable_one_ff;
  reg [2:0] irq_enable_two_ff;
  reg [2:0] nxt_cause_evt;
  reg [3:0] irq_cause_one;
  reg [2:0] irq_cause_two;
  reg [`DATA_W-1:0] nxt_rdata;

  sticky_flags #(.WIDTH(4)) u_low_wire (
    .clk_sys(clk_sys),
    .rst(rst),
    .event_in({low_wire_short_vdd, low_wire_short_gnd, low_wire_short_bat, low_wire_open}),
    .clear(rd_low_wire),
    .flags_ff(low_wire_flags)
  );

  // Bit 1 is tied low here and read from the live input, so it never latches.
  sticky_flags #(.WIDTH(4)) u_supply (
    .clk_sys(clk_sys),
    .rst(rst),
    .event_in({switched_supply_overtemp, secondary_regulator_on, 1'b0, battery_fail}),
    .clear(rd_supply),
    .flags_ff(supply_latched)
  );

  sticky_flags #(.WIDTH(1)) u_xcvr_ot (
    .clk_sys(clk_sys),
    .rst(rst),
    .event_in(transceiver_overtemp),
    .clear(rd_xcvr),
    .flags_ff(xcvr_ot)
  );

  xcvr_state_ctrl u_xcvr (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_sel(wr_xcvr),
    .wr_data(reg_wdata[2:0]),
    .chip_mode(chip_mode),
    .force_term(force_term),
    .selected_ff(xcvr_sel),
    .transceiver_state_ff(xcvr_state)
  );

  always @*
  begin
    nxt_cause_evt = 3'h0;
    if (undervoltage_reset)
      nxt_cause_evt = nxt_cause_evt | `RC_EVT_UNDERVOLT;
    if (watchdog_reset)
      nxt_cause_evt = nxt_cause_evt | `RC_EVT_WATCHDOG;
    if (external_reset)
      nxt_cause_evt = nxt_cause_evt | `RC_EVT_EXTERNAL;
  end

  // Reset cause is kept through a reset-pin event; only power-on reloads it.
  always @(posedge clk_sys)
  begin
    if (rst)
      reset_cause_ff <= `RESET_CAUSE_POR;
    else if (rd_reset_cause)
      reset_cause_ff <= nxt_cause_evt;
    else
      reset_cause_ff <= reset_cause_ff | nxt_cause_evt;
  end

  always @(posedge clk_sys)
  begin
    if (rst || !reset_pin_n)
    begin
      irq_enable_one_ff <= 4'h0;
      irq_enable_two_ff <= 3'h0;
    end
    else if (reg_wr && reg_addr == `OFF_IRQ_EN_ONE)
      irq_enable_one_ff <= reg_wdata[3:0];
    else if (reg_wr && reg_addr == `OFF_IRQ_EN_TWO)
      irq_enable_two_ff <= reg_wdata[2:0];
  end

  // Source copies are pure wiring of the flags, so a read of them has no side effect.
  always @*
  begin
    irq_cause_one = {battery_high, regulator_hot, temp_prewarn, supply_latched[`SS_BAT_LOW]};
    irq_cause_two = {bus_failure, serial_error, wakeup};
  end

  always @*
  begin
    nxt_rdata = 8'h00;
    if (reg_addr == `OFF_LOW_WIRE)
      nxt_rdata = {4'h0, low_wire_flags};
    else if (reg_addr == `OFF_RESET_CAUSE)
      nxt_rdata = {5'h00, reset_cause_ff};
    else if (reg_addr == `OFF_SUPPLY_STATUS)
      nxt_rdata = {4'h0, supply_latched[3:2], battery_high, supply_latched[0]};
    else if (reg_addr == `OFF_IRQ_EN_ONE)
      nxt_rdata = {4'h0, irq_enable_one_ff};
    else if (reg_addr == `OFF_IRQ_EN_TWO)
      nxt_rdata = {5'h00, irq_enable_two_ff};
    else if (reg_addr == `OFF_IRQ_CAUSE_ONE)
      nxt_rdata = {4'h0, irq_cause_one};
    else if (reg_addr == `OFF_IRQ_CAUSE_TWO)
      nxt_rdata = {5'h00, irq_cause_two};
    else if (reg_addr == `OFF_XCVR_CTRL)
      nxt_rdata = {4'h0, xcvr_ot, xcvr_state};
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata_ff <= 8'h00;
      reg_ack_ff <= 1'b0;
      transceiver_state_ff <= `XS_TERM_BAT;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata_ff <= nxt_rdata;
      reg_ack_ff <= reg_rd || reg_wr;
      transceiver_state_ff <= xcvr_state;
      irq_ff <= |(irq_cause_one & irq_enable_one_ff) | |(irq_cause_two & irq_enable_two_ff);
    end
  end
endmodule

// *** supply_can_status_irq_regs_test.sv ***
// Directed scenarios for the status, mask and transceiver registers.
`timescale 1ns/1ns
`include "sbc_regs_defines.vh"
module supply_can_status_irq_regs_test;
  reg clk_sys = 0, rst = 1, reset_pin_n = 1, force_term = 0;
  reg [7:0] ev = 0;
  reg [3:0] sup = 0;
  reg [4:0] live = 0;
  reg [1:0] chip_mode = 0;
  wire reg_wr, reg_rd, reg_ack_ff, irq_ff;
  wire [5:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata_ff;
  wire [2:0] xs;
  integer n_fail = 0, checks_done = 0;
  reg [7:0] q;
  always #50 clk_sys = ~clk_sys;
  host_model host (.clk_sys, .reg_ack_ff, .reg_rdata_ff, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  supply_can_status_irq_regs uut (.clk_sys, .rst, .reset_pin_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata_ff, .reg_ack_ff, .low_wire_open(ev[0]), .low_wire_short_bat(ev[1]),
    .low_wire_short_gnd(ev[2]), .low_wire_short_vdd(ev[3]), .undervoltage_reset(ev[4]),
    .watchdog_reset(ev[5]), .external_reset(ev[6]), .transceiver_overtemp(ev[7]),
    .battery_fail(sup[0]), .battery_high(sup[1]), .secondary_regulator_on(sup[2]),
    .switched_supply_overtemp(sup[3]), .regulator_hot(live[4]), .temp_prewarn(live[3]),
    .bus_failure(live[2]), .serial_error(live[1]), .wakeup(live[0]), .chip_mode,
    .force_term, .transceiver_state_ff(xs), .irq_ff);
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) n_fail = n_fail + 1;
    if (seen !== exp) $display("wrong value %0s exp %h seen %h", nm, exp, seen);
  endtask
  task rd(input [5:0] a, input [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task wr(input [5:0] a, input [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys) #1;
  endtask
  task hang;
    n_fail = n_fail + 1;
    report_and_stop;
  endtask
  task report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task t_por;
    rd(`OFF_RESET_CAUSE, 8'h05);
    rd(`OFF_RESET_CAUSE, 8'h00);
    rd(`OFF_LOW_WIRE, 8'h00);
    rd(`OFF_XCVR_CTRL, 8'h00);
    rd(6'h30, 8'h00);
  endtask
  // Wire faults and reset causes pulse together to show the two banks do not interfere.
  task t_events;
    ev = 8'h25;
    tick(1);
    ev = 8'h4a;
    tick(1);
    ev = 8'h00;
    rd(`OFF_LOW_WIRE, 8'h0f);
    rd(`OFF_LOW_WIRE, 8'h00);
    rd(`OFF_RESET_CAUSE, 8'h06);
    ev = 8'h10;
    tick(1);
    ev = 8'h00;
    rd(`OFF_RESET_CAUSE, 8'h05);
    wr(`OFF_RESET_CAUSE, 8'h07);
    rd(`OFF_RESET_CAUSE, 8'h00);
  endtask
  task t_supply;
    sup = 4'hf;
    tick(1);
    sup = 4'h2;
    rd(`OFF_SUPPLY_STATUS, 8'h0f);
    rd(`OFF_SUPPLY_STATUS, 8'h02);
  endtask
  task t_irq;
    wr(`OFF_IRQ_EN_ONE, 8'h08);
    live = 5'h1f;
    // A battery-low pulse leaves a latched flag, so a clearing source read would show up.
    sup = 4'h3;
    tick(2);
    sup = 4'h2;
    chk("irq", irq_ff, 8'h01);
    rd(`OFF_IRQ_CAUSE_ONE, 8'h0f);
    rd(`OFF_IRQ_CAUSE_ONE, 8'h0f);
    rd(`OFF_IRQ_CAUSE_TWO, 8'h07);
    rd(`OFF_IRQ_EN_ONE, 8'h08);
    rd(`OFF_SUPPLY_STATUS, 8'h03);
    wr(`OFF_IRQ_EN_ONE, 8'h01);
    tick(2);
    chk("irq", irq_ff, 8'h00);
    wr(`OFF_IRQ_EN_TWO, 8'h07);
    rd(`OFF_IRQ_EN_TWO, 8'h07);
    reset_pin_n = 0;
    tick(1);
    reset_pin_n = 1;
    rd(`OFF_IRQ_EN_TWO, 8'h00);
    chk("irq", irq_ff, 8'h00);
  endtask
  task t_xcvr;
    wr(`OFF_XCVR_CTRL, 8'h03);
    tick(1);
    chk("state", xs, 8'h03);
    chip_mode = `MODE_STANDBY;
    tick(3);
    chk("state", xs, 8'h02);
    chip_mode = `MODE_SLEEP;
    tick(3);
    chip_mode = `MODE_NORMAL;
    rd(`OFF_XCVR_CTRL, 8'h00);
    wr(`OFF_XCVR_CTRL, 8'h02);
    reset_pin_n = 0;
    ev = 8'h80;
    tick(1);
    ev = 8'h00;
    reset_pin_n = 1;
    rd(`OFF_XCVR_CTRL, 8'h0a);
    rd(`OFF_XCVR_CTRL, 8'h02);
    force_term = 1;
    tick(3);
    force_term = 0;
    rd(`OFF_XCVR_CTRL, 8'h00);
    wr(`OFF_XCVR_CTRL, 8'h07);
    rd(`OFF_XCVR_CTRL, 8'h00);
  endtask
  initial
  begin
    tick(8);
    rst = 0;
    t_por;
    t_events;
    t_supply;
    t_irq;
    t_xcvr;
    report_and_stop;
  end
endmodule

// *** xcvr_state_ctrl.v ***
// Transceiver state selection, overridden by the chip operating mode.
`timescale 1ns/1ns
`include "sbc_regs_defines.vh"
module xcvr_state_ctrl (
  input wire clk_sys,
  input wire rst,
  input wire wr_sel,
  input wire [2:0] wr_data,
  input wire [1:0] chip_mode,
  input wire force_term,
  output reg [2:0] selected_ff,
  output reg [2:0] transceiver_state_ff
);
  reg [2:0] nxt_selected;
  reg [2:0] nxt_state;
  always @*
  begin
    nxt_selected = selected_ff;
    if (wr_sel)
      nxt_selected = wr_data;
    nxt_state = nxt_selected;
    // Only the three documented codes are accepted; others fall back to termination.
    if (nxt_state != `XS_RX_ONLY && nxt_state != `XS_RX_TX)
      nxt_state = `XS_TERM_BAT;
    if (chip_mode == `MODE_SLEEP)
      nxt_state = `XS_TERM_BAT;
    else if (chip_mode == `MODE_STANDBY && nxt_state == `XS_RX_TX)
      nxt_state = `XS_RX_ONLY;
    if (force_term || nxt_state == `XS_TERM_BAT)
    begin
      nxt_state = `XS_TERM_BAT;
      nxt_selected = {nxt_selected[2], 2'b00};
    end
  end
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      selected_ff <= 3'h0;
      transceiver_state_ff <= `XS_TERM_BAT;
    end
    else
    begin
      selected_ff <= nxt_selected;
      transceiver_state_ff <= nxt_state;
    end
  end
endmodule
